// >>> hw/dcdr_byte_store.sv
// Small byte store holding the clamp and diagnostic enable registers
`timescale 1ns/1ps
module dcdr_byte_store #(
   parameter int NUM_BYTES = 5
) (
   input wire logic clk,                       // System clock
   input wire logic reset,                     // Synchronous reset, active high
   input wire logic wr_en,                     // Write strobe
   input wire logic [2:0] wr_idx,              // Write byte index
   input wire logic [7:0] wr_data,             // Write byte
   input wire logic rd_en,                     // Read strobe
   input wire logic rd_hit,                    // Read index is mapped
   input wire logic [2:0] rd_idx,              // Read byte index
   output logic [7:0] rd_data,                 // Registered read byte
   output logic [8*NUM_BYTES-1:0] contents     // All stored bytes, flat
);
   import dcdr_pkg::*;

   initial begin
      if (NUM_BYTES < 1 || NUM_BYTES > 8) begin
         $error("dcdr_byte_store: NUM_BYTES out of range");
      end
   end

   logic [7:0] mem_q [NUM_BYTES];
   logic [7:0] rd_data_q;
   logic [7:0] rd_sel;

   assign rd_sel = rd_hit ? mem_q[rd_idx] : 8'h00;

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            mem_q[i] <= DCDR_BYTE_RESET;
         end
      end else if (wr_en) begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         rd_data_q <= rd_sel;
      end
   end

   assign rd_data = rd_data_q;

   genvar g;
   generate
      for (g = 0; g < NUM_BYTES; g++) begin : g_flat
         assign contents[8*g +: 8] = mem_q[g];
      end
   endgenerate
endmodule : dcdr_byte_store

// >>> hw/dcdr_pkg.sv
// Package of offsets, field positions and reset values for the clamp and diagnostic registers
package dcdr_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] DCDR_FLOOR_LSB_ADDR = 32'h4000_0036;
   localparam logic [31:0] DCDR_FLOOR_MSB_ADDR = 32'h4000_0037;
   localparam logic [31:0] DCDR_CEIL_LSB_ADDR = 32'h4000_0038;
   localparam logic [31:0] DCDR_CEIL_MSB_ADDR = 32'h4000_0039;
   localparam logic [31:0] DCDR_DIAG_EN_ADDR = 32'h4000_003A;

   // ------------------------------------------------------------
   // Byte store layout
   // ------------------------------------------------------------
   localparam int DCDR_NUM_BYTES = 5;
   localparam logic [2:0] DCDR_IDX_FLOOR_LSB = 3'h0;
   localparam logic [2:0] DCDR_IDX_FLOOR_MSB = 3'h1;
   localparam logic [2:0] DCDR_IDX_CEIL_LSB = 3'h2;
   localparam logic [2:0] DCDR_IDX_CEIL_MSB = 3'h3;
   localparam logic [2:0] DCDR_IDX_DIAG_EN = 3'h4;
   localparam logic [7:0] DCDR_BYTE_RESET = 8'h00;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int DCDR_CLAMP_W = 12;
   localparam int DCDR_DAC_W = 16;
   localparam int DCDR_NUM_CHECKS = 8;
   localparam int DCDR_BIT_PRESS_IN_OV = 0;
   localparam int DCDR_BIT_PRESS_IN_UV = 1;
   localparam int DCDR_BIT_TEMP_IN_OV = 2;
   localparam int DCDR_BIT_RESERVED = 3;
   localparam int DCDR_BIT_PRESS_AMP_OV = 4;
   localparam int DCDR_BIT_PRESS_AMP_UV = 5;
   localparam int DCDR_BIT_TEMP_AMP_OV = 6;
   localparam int DCDR_BIT_TEMP_AMP_UV = 7;
   localparam logic [7:0] DCDR_FAULT_LOW_BYTE = 8'h00;
   localparam logic [7:0] DCDR_CHECK_MASK = 8'hF7;
   localparam logic [15:0] DCDR_DAC_RESET = 16'h0000;
endpackage : dcdr_pkg

// >>> hw/dcdr_regs.sv
// Clamp and diagnostic enable registers with the output DAC code selection
`timescale 1ns/1ps

// What this block does
// - Twelve-bit lower clamp in bits 0 to 11, read/write, reset to zero.
// - Twelve-bit upper clamp in its own two-byte register, read/write, reset zero.
// - Enable bit 0 arms pressure-input overvoltage, bit 1 pressure-input undervoltage.
// - Enable bit 2 arms temperature-input overvoltage; bit 3 reserved but read/write.
// - Enable bits 4 and 5 arm pressure amplifier over- and undervoltage checks.
// - Enable bits 6 and 7 arm temperature amplifier over- and undervoltage checks.
// - All eight enable bits read/write, reset to zero, every check off.
// - Code below the normal lower threshold is replaced by the lower clamp.
// - Code above the normal upper threshold is replaced by the upper clamp.
// - Enabled fault drives the fault code, its low byte fixed at zero.
module dcdr_regs #(
   parameter int CODE_W = 12
) (
   input wire logic clk,                         // System clock, 20 MHz
   input wire logic reset,                       // Synchronous reset, active high
   input wire logic [31:0] cfg_addr,             // Configuration byte address
   input wire logic cfg_wr_en,                   // Configuration write strobe
   input wire logic [7:0] cfg_wr_data,           // Configuration write byte
   input wire logic cfg_rd_en,                   // Configuration read strobe
   output logic [7:0] cfg_rd_data,               // Configuration read byte
   input wire logic [CODE_W-1:0] comp_code,      // Compensated output code
   input wire logic [CODE_W-1:0] normal_low,     // Normal window lower threshold
   input wire logic [CODE_W-1:0] normal_high,    // Normal window upper threshold
   input wire logic [7:0] fault_code_msb,        // Programmed fault code upper byte
   input wire logic [7:0] check_fail,            // Raw diagnostic failures, enable layout
   output logic [15:0] dac_code,                 // Code driven to the output DAC
   output logic fault_active,                    // Fault code being driven
   output logic press_in_overvolt_en,            // Pressure input overvoltage check on
   output logic press_in_undervolt_en,           // Pressure input undervoltage check on
   output logic temp_in_overvolt_en,             // Temperature input overvoltage check on
   output logic press_amp_overvolt_en,           // Pressure amplifier overvoltage check on
   output logic press_amp_undervolt_en,          // Pressure amplifier undervoltage check on
   output logic temp_amp_overvolt_en,            // Temperature amplifier overvoltage check on
   output logic temp_amp_undervolt_en            // Temperature amplifier undervoltage check on
);
   import dcdr_pkg::*;

   initial begin
      if (CODE_W != DCDR_CLAMP_W) begin
         $error("dcdr_regs: CODE_W must match the clamp field width");
      end
      if (CODE_W > DCDR_DAC_W) begin
         $error("dcdr_regs: CODE_W must not exceed the DAC code width");
      end
      if (DCDR_NUM_BYTES > 8) begin
         $error("dcdr_regs: byte store index is only three bits wide");
      end
      if (DCDR_CHECK_MASK[DCDR_BIT_RESERVED] != 1'b0) begin
         $error("dcdr_regs: reserved enable bit must not arm a check");
      end
   end

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic [3:0] decode_addr(input logic [31:0] addr);
      logic [3:0] res;
      res = 4'h0;
      case (addr)
         DCDR_FLOOR_LSB_ADDR: res = {1'b1, DCDR_IDX_FLOOR_LSB};
         DCDR_FLOOR_MSB_ADDR: res = {1'b1, DCDR_IDX_FLOOR_MSB};
         DCDR_CEIL_LSB_ADDR: res = {1'b1, DCDR_IDX_CEIL_LSB};
         DCDR_CEIL_MSB_ADDR: res = {1'b1, DCDR_IDX_CEIL_MSB};
         DCDR_DIAG_EN_ADDR: res = {1'b1, DCDR_IDX_DIAG_EN};
         default: res = 4'h0;
      endcase
      return res;
   endfunction : decode_addr

   logic [3:0] dec;
   logic addr_hit;
   logic [2:0] addr_idx;
   logic store_wr;
   logic [8*DCDR_NUM_BYTES-1:0] store;

   assign dec = decode_addr(cfg_addr);
   assign addr_hit = dec[3];
   assign addr_idx = dec[2:0];
   // Writes to unmapped addresses are dropped
   assign store_wr = cfg_wr_en && addr_hit;

   dcdr_byte_store #(
      .NUM_BYTES(DCDR_NUM_BYTES)
   ) u_store (
      .clk(clk),
      .reset(reset),
      .wr_en(store_wr),
      .wr_idx(addr_idx),
      .wr_data(cfg_wr_data),
      .rd_en(cfg_rd_en),
      .rd_hit(addr_hit),
      .rd_idx(addr_idx),
      .rd_data(cfg_rd_data),
      .contents(store)
   );

   // ------------------------------------------------------------
   // Register fields
   // ------------------------------------------------------------
   // Picks one byte out of the flat store image
   function automatic logic [7:0] byte_at(input logic [8*DCDR_NUM_BYTES-1:0] img,
      input logic [2:0] idx);
      logic [7:0] res;
      res = img[8*idx +: 8];
      return res;
   endfunction : byte_at

   // Widens a clamp-width code to the DAC width, zeros on top
   function automatic logic [15:0] widen(input logic [CODE_W-1:0] code);
      logic [15:0] res;
      res = {{(DCDR_DAC_W-CODE_W){1'b0}}, code};
      return res;
   endfunction : widen

   logic [15:0] floor_reg;
   logic [15:0] ceil_reg;
   logic [7:0] check_en;
   logic [CODE_W-1:0] floor_val;
   logic [CODE_W-1:0] ceil_val;

   assign floor_reg = {byte_at(store, DCDR_IDX_FLOOR_MSB), byte_at(store, DCDR_IDX_FLOOR_LSB)};
   assign ceil_reg = {byte_at(store, DCDR_IDX_CEIL_MSB), byte_at(store, DCDR_IDX_CEIL_LSB)};
   assign check_en = byte_at(store, DCDR_IDX_DIAG_EN);
   assign floor_val = floor_reg[CODE_W-1:0];
   assign ceil_val = ceil_reg[CODE_W-1:0];

   // ------------------------------------------------------------
   // Output code selection
   // ------------------------------------------------------------
   // A failure counts only when its own enable bit is set
   function automatic logic armed_bit(input logic [7:0] fail, input logic [7:0] en,
      input int pos);
      logic res;
      res = fail[pos] && en[pos];
      return res;
   endfunction : armed_bit

   // Reserved bit 3 stores data but arms nothing
   function automatic logic [7:0] live_enables(input logic [7:0] en);
      logic [7:0] res;
      res = en & DCDR_CHECK_MASK;
      return res;
   endfunction : live_enables

   logic p_in_ov_hit;
   logic p_in_uv_hit;
   logic t_in_ov_hit;
   logic p_amp_ov_hit;
   logic p_amp_uv_hit;
   logic t_amp_ov_hit;
   logic t_amp_uv_hit;
   logic [7:0] armed_fail;
   logic fault_d;
   logic below;
   logic above;
   logic [15:0] dac_d;
   logic [15:0] dac_q;
   logic fault_q;
   logic [7:0] en_q;

   assign p_in_ov_hit = armed_bit(check_fail, check_en, DCDR_BIT_PRESS_IN_OV);
   assign p_in_uv_hit = armed_bit(check_fail, check_en, DCDR_BIT_PRESS_IN_UV);
   assign t_in_ov_hit = armed_bit(check_fail, check_en, DCDR_BIT_TEMP_IN_OV);
   assign p_amp_ov_hit = armed_bit(check_fail, check_en, DCDR_BIT_PRESS_AMP_OV);
   assign p_amp_uv_hit = armed_bit(check_fail, check_en, DCDR_BIT_PRESS_AMP_UV);
   assign t_amp_ov_hit = armed_bit(check_fail, check_en, DCDR_BIT_TEMP_AMP_OV);
   assign t_amp_uv_hit = armed_bit(check_fail, check_en, DCDR_BIT_TEMP_AMP_UV);
   assign armed_fail = live_enables({t_amp_uv_hit, t_amp_ov_hit, p_amp_uv_hit, p_amp_ov_hit,
      1'b0, t_in_ov_hit, p_in_uv_hit, p_in_ov_hit});
   assign fault_d = |armed_fail;
   assign below = comp_code < normal_low;
   assign above = comp_code > normal_high;
   // Fault has priority over the clamps
   assign dac_d = fault_d ? {fault_code_msb, DCDR_FAULT_LOW_BYTE} :
      below ? widen(floor_val) :
      above ? widen(ceil_val) :
      widen(comp_code);

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         dac_q <= DCDR_DAC_RESET;
      end else begin
         dac_q <= dac_d;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         en_q <= DCDR_BYTE_RESET;
      end else begin
         en_q <= live_enables(check_en);
      end
   end

   assign dac_code = dac_q;
   assign fault_active = fault_q;
   assign press_in_overvolt_en = en_q[DCDR_BIT_PRESS_IN_OV];
   assign press_in_undervolt_en = en_q[DCDR_BIT_PRESS_IN_UV];
   assign temp_in_overvolt_en = en_q[DCDR_BIT_TEMP_IN_OV];
   assign press_amp_overvolt_en = en_q[DCDR_BIT_PRESS_AMP_OV];
   assign press_amp_undervolt_en = en_q[DCDR_BIT_PRESS_AMP_UV];
   assign temp_amp_overvolt_en = en_q[DCDR_BIT_TEMP_AMP_OV];
   assign temp_amp_undervolt_en = en_q[DCDR_BIT_TEMP_AMP_UV];
endmodule : dcdr_regs

// >>> test/dcdr_regs_asserts.sv
// Checker of the clamp and diagnostic enable registers
`timescale 1ns/1ps
module dcdr_regs_asserts import dcdr_pkg::*; #(
   parameter int CODE_W = 12
) (
   input wire logic clk, // In
   input wire logic reset, // In
   input wire logic [31:0] cfg_addr, // In
   input wire logic cfg_wr_en, // In
   input wire logic [7:0] cfg_wr_data, // In
   input wire logic cfg_rd_en, // In
   input wire logic [7:0] cfg_rd_data, // In
   input wire logic [CODE_W-1:0] comp_code, // In
   input wire logic [CODE_W-1:0] normal_low, // In
   input wire logic [CODE_W-1:0] normal_high, // In
   input wire logic [7:0] fault_code_msb, // In
   input wire logic [7:0] check_fail, // In
   input wire logic [15:0] dac_code, // In
   input wire logic fault_active, // In
   input wire logic press_in_overvolt_en, // In
   input wire logic press_in_undervolt_en, // In
   input wire logic temp_in_overvolt_en, // In
   input wire logic press_amp_overvolt_en, // In
   input wire logic press_amp_undervolt_en, // In
   input wire logic temp_amp_overvolt_en, // In
   input wire logic temp_amp_undervolt_en // In
);
   logic [7:0] en_w;
   logic armed;
   logic mapped;
   assign en_w = {temp_amp_undervolt_en, temp_amp_overvolt_en, press_amp_undervolt_en,
      press_amp_overvolt_en, 1'b0, temp_in_overvolt_en, press_in_undervolt_en,
      press_in_overvolt_en};
   assign armed = |(check_fail & en_w);
   assign mapped = cfg_addr >= DCDR_FLOOR_LSB_ADDR && cfg_addr <= DCDR_DIAG_EN_ADDR;
   // Shadow of the clamp registers, rebuilt from the write traffic
   logic [15:0] floor_sh;
   logic [15:0] ceil_sh;
   always_ff @(posedge clk) begin
      if (reset) begin
         floor_sh <= 16'h0000;
         ceil_sh <= 16'h0000;
      end else if (cfg_wr_en) begin
         case (cfg_addr)
            DCDR_FLOOR_LSB_ADDR: floor_sh[7:0] <= cfg_wr_data;
            DCDR_FLOOR_MSB_ADDR: floor_sh[15:8] <= cfg_wr_data;
            DCDR_CEIL_LSB_ADDR: ceil_sh[7:0] <= cfg_wr_data;
            DCDR_CEIL_MSB_ADDR: ceil_sh[15:8] <= cfg_wr_data;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_FAULT: assert property (armed && !$past(cfg_wr_en) |=> fault_active
      && dac_code == {$past(fault_code_msb), 8'h00}) else $error("fault code missing");
   AST_UNARMED: assert property (!armed && !$past(cfg_wr_en) |=> !fault_active)
      else $error("unarmed fault");
   AST_BIT3: assert property ((check_fail & DCDR_CHECK_MASK) == 8'h00 |=> !fault_active)
      else $error("reserved bit armed");
   AST_PASS: assert property (!armed && !$past(cfg_wr_en) && comp_code >= normal_low
      && comp_code <= normal_high |=> dac_code == 16'($past(comp_code))) else $error("pass");
   AST_FLOOR: assert property (!armed && !$past(cfg_wr_en) && comp_code < normal_low
      |=> !fault_active && dac_code == {4'h0, $past(floor_sh[11:0])}) else $error("floor");
   AST_CEIL: assert property (!armed && !$past(cfg_wr_en) && comp_code > normal_high
      && comp_code >= normal_low |=> !fault_active && dac_code == {4'h0, $past(ceil_sh[11:0])})
      else $error("ceiling");
   AST_ENABLES: assert property (cfg_wr_en && cfg_addr == DCDR_DIAG_EN_ADDR
      |-> ##2 en_w == ($past(cfg_wr_data, 2) & DCDR_CHECK_MASK)) else $error("enables");
   AST_READBACK: assert property (cfg_wr_en && mapped ##1 !cfg_wr_en ##1 cfg_rd_en
      && !cfg_wr_en && cfg_addr == $past(cfg_addr, 2) |=> cfg_rd_data == $past(cfg_wr_data, 3))
      else $error("readback");
endmodule : dcdr_regs_asserts
bind dcdr_regs dcdr_regs_asserts #(.CODE_W(CODE_W)) chk_u (.*);

// >>> test/dcdr_regs_tb.sv
// Self-checking bench of the clamp and diagnostic enable registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s expected %h seen %h", n, e, g); end end
module dcdr_regs_tb;
   import dcdr_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] addr = 32'h0000_0000;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [11:0] comp = 12'h000;
   logic [11:0] lo = 12'h100;
   logic [11:0] hi = 12'hE00;
   logic [7:0] fail = 8'h00;
   logic [7:0] fcm = 8'hA5;
   logic [7:0] rdat;
   logic [15:0] dac;
   logic fa;
   wire [7:0] en;
   int miscompares = 0;
   int n_tests = 0;
   int i;
   dcdr_regs #(.CODE_W(12)) dut_u (.clk(clk), .reset(reset), .cfg_addr(addr), .cfg_wr_en(we),
      .cfg_wr_data(wd), .cfg_rd_en(re), .cfg_rd_data(rdat), .comp_code(comp), .normal_low(lo),
      .normal_high(hi), .fault_code_msb(fcm), .check_fail(fail), .dac_code(dac),
      .fault_active(fa), .press_in_overvolt_en(en[0]), .press_in_undervolt_en(en[1]),
      .temp_in_overvolt_en(en[2]), .press_amp_overvolt_en(en[4]),
      .press_amp_undervolt_en(en[5]), .temp_amp_overvolt_en(en[6]),
      .temp_amp_undervolt_en(en[7]));
   assign en[3] = 1'b0;
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      we <= 1'b1;
      wd <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      `CHK("cfg_rd_data", e, rdat)
   endtask : rdc
   task automatic dchk(input logic [11:0] c, input logic [7:0] f, input logic [15:0] e,
      input logic ef);
      @(posedge clk);
      comp <= c;
      fail <= f;
      @(posedge clk);
      #1;
      `CHK("dac_code", e, dac)
      `CHK("fault_active", ef, fa)
   endtask : dchk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #(50 * 4000);
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (i = 0; i < 5; i++) rdc(DCDR_FLOOR_LSB_ADDR + i, 8'h00);
      `CHK("enables", 8'h00, en & DCDR_CHECK_MASK)
      wr(DCDR_FLOOR_LSB_ADDR, 8'h34);
      wr(DCDR_FLOOR_MSB_ADDR, 8'hF2);
      wr(DCDR_CEIL_LSB_ADDR, 8'hCD);
      wr(DCDR_CEIL_MSB_ADDR, 8'h0E);
      wr(32'h4000_003B, 8'h55);
      rdc(DCDR_FLOOR_MSB_ADDR, 8'hF2);
      rdc(32'h4000_003B, 8'h00);
      dchk(12'h0FF, 8'h00, 16'h0234, 1'b0);
      dchk(12'h100, 8'h00, 16'h0100, 1'b0);
      dchk(12'hE00, 8'h00, 16'h0E00, 1'b0);
      dchk(12'hE01, 8'h00, 16'h0ECD, 1'b0);
      for (i = 0; i < 8; i++) begin
         wr(DCDR_DIAG_EN_ADDR, 8'h01 << i);
         rdc(DCDR_DIAG_EN_ADDR, 8'h01 << i);
         dchk(12'h0FF, 8'hFF, (i == 3) ? 16'h0234 : 16'hA500, i != 3);
         dchk(12'hE01, ~(8'h01 << i), 16'h0ECD, 1'b0);
         `CHK("enables", (8'h01 << i) & DCDR_CHECK_MASK, en & DCDR_CHECK_MASK)
      end
      @(posedge clk);
      fcm <= 8'h3C;
      dchk(12'h800, 8'h80, 16'h3C00, 1'b1);
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rdc(DCDR_FLOOR_LSB_ADDR, 8'h00);
      rdc(DCDR_DIAG_EN_ADDR, 8'h00);
      `CHK("enables", 8'h00, en & DCDR_CHECK_MASK)
      print_verdict();
   end
endmodule : dcdr_regs_tb
